// [include/apf_pkg.sv]
`default_nettype none
package apf_pkg;
  // ==========================================================================
  // Packet layout constants
  // ==========================================================================
  localparam int unsigned        QUAD_W         = 32;
  localparam int unsigned        FIFO_DEPTH     = 16;
  localparam logic [9:0]         LOCAL_BUS_NUM  = 10'h3FF;
  localparam logic [3:0]         PRIORITY_ZERO  = 4'h0;
  localparam logic [15:0]        EXT_TCODE_ZERO = 16'h0000;
  localparam logic [3:0]         TCODE_QWRITE   = 4'h0;
  localparam logic [3:0]         TCODE_BWRITE   = 4'h1;
  localparam logic [3:0]         TCODE_QREAD    = 4'h4;
  localparam logic [3:0]         TCODE_BREAD    = 4'h5;
  localparam logic [3:0]         TCODE_QRESP    = 4'h6;
  localparam logic [3:0]         TCODE_BRESP    = 4'h7;
  localparam logic [3:0]         TCODE_LOCK_REQ = 4'h9;
  localparam logic [3:0]         TCODE_LOCK_RSP = 4'hB;
  // Field positions inside header quadlet 0.
  localparam int unsigned        TCODE_LSB      = 4;
  localparam int unsigned        PRI_LSB        = 0;
  localparam int unsigned        BUSSEL_BIT     = 23;
  // Field positions inside header quadlet 1 / 3.
  localparam int unsigned        SRC_BUS_LSB    = 22;
  localparam int unsigned        EXT_LSB        = 0;
  localparam logic [9:0]         BUS_NUM_RESET  = 10'h000;
endpackage : apf_pkg
`default_nettype wire

// [rtl/apf_top.sv]
// Operation
// - Bus-select bit set forces source bus 3FF, else programmed bus number.
// - Stored received block packets carry priority 0000b.
// - Node IDs are 16 bits: 10-bit bus, 6-bit node.
// - Stored non-lock block packets carry extended code 0000h.
// - Stored packet ends with the acknowledge code returned.
// - Stored packet records the arrival speed code.
// - Stored packet holds sender's 16-bit source identifier.
// - Stored packet holds the 48-bit destination offset.
// - Retry field passes from host on transmit, stored on receive.
// - Transaction code passes on transmit and is stored on receive.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Synchronous FIFO
// ============================================================================
module apf_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             push, pop;

  // Honest full and empty from the occupancy count.
  always_comb
  begin
    in_ready_o  = (count_r != (AW+1)'(DEPTH)); // Full at exactly DEPTH words held.
    out_valid_o = (count_r != '0);
    out_data_o  = mem_r[rd_ptr_r];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_ptr_nxt  = push ? ((wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1)) : wr_ptr_r;
    rd_ptr_nxt  = pop ? ((rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1)) : rd_ptr_r;
    count_nxt   = count_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage keeps arrival order; words leave oldest first.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
    if (srst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end
endmodule : apf_fifo

// ============================================================================
// Asynchronous packet framer
// ============================================================================
module apf_top #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic        REF_CLK_I,
  input  wire logic        SRST_I,
  // Configuration.
  input  wire logic [9:0]  BUS_NUMBER_I,
  // Transmit side: host writes quadlets.
  input  wire logic        TX_HOST_VALID_I,
  input  wire logic [31:0] TX_HOST_DATA_I,
  input  wire logic        TX_HOST_SOP_I,
  output logic             TX_HOST_READY_O,
  // Transmit side: link takes formatted quadlets.
  output logic             TX_LINK_VALID_O,
  output logic [31:0]      TX_LINK_DATA_O,
  input  wire logic        TX_LINK_READY_I,
  // Receive side: link delivers quadlets.
  input  wire logic        RX_LINK_VALID_I,
  input  wire logic [31:0] RX_LINK_DATA_I,
  input  wire logic        RX_LINK_SOP_I,
  input  wire logic        RX_LINK_EOP_I,
  input  wire logic [1:0]  RX_LINK_SPEED_I,
  input  wire logic [3:0]  RX_LINK_ACK_I,
  output logic             RX_LINK_READY_O,
  // Receive side: host drains stored quadlets.
  output logic             RX_HOST_VALID_O,
  output logic [31:0]      RX_HOST_DATA_O,
  input  wire logic        RX_HOST_READY_I
);
  typedef enum logic [1:0] {RX_DATA, RX_TRAIL} apf_rx_type;

  logic [2:0]        tx_idx_r, tx_idx_nxt;
  logic              tx_bussel_r, tx_bussel_nxt;
  logic [31:0]       tx_word;
  logic [2:0]        rx_idx_r, rx_idx_nxt;
  logic [3:0]        rx_tcode_r, rx_tcode_nxt;
  apf_rx_type        rx_st_r, rx_st_nxt;
  logic              rx_fifo_valid, rx_fifo_ready, tx_fifo_ready;
  logic [31:0]       rx_word;

  // Lock packets keep the extended code; block write, read and response codes store zero.
  function automatic logic is_lock(input logic [3:0] tc);
    is_lock = (tc == apf_pkg::TCODE_LOCK_REQ) || (tc == apf_pkg::TCODE_LOCK_RSP);
  endfunction : is_lock

  // Transmit header rewrite: quadlet 1 gets the source bus inserted.
  always_comb
  begin
    tx_word       = TX_HOST_DATA_I;
    tx_bussel_nxt = tx_bussel_r;
    tx_idx_nxt    = tx_idx_r;
    if (TX_HOST_VALID_I && TX_HOST_SOP_I)
    begin
      tx_bussel_nxt = TX_HOST_DATA_I[apf_pkg::BUSSEL_BIT];
    end
    if (!TX_HOST_SOP_I && tx_idx_r == 3'd1)
    begin
      // Source bus field: 10-bit bus number above a 6-bit node.
      tx_word[apf_pkg::SRC_BUS_LSB +: 10] = tx_bussel_r ? apf_pkg::LOCAL_BUS_NUM : BUS_NUMBER_I;
    end
    if (TX_HOST_VALID_I && tx_fifo_ready)
    begin
      tx_idx_nxt = TX_HOST_SOP_I ? 3'd1 : ((tx_idx_r == 3'd7) ? tx_idx_r : tx_idx_r + 3'd1);
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      tx_idx_r    <= 3'd0;
      tx_bussel_r <= 1'b0;
    end
    else
    begin
      tx_idx_r    <= tx_idx_nxt;
      tx_bussel_r <= tx_bussel_nxt;
    end
  end

  // Transmit path buffer; retry, label and code pass untouched.
  apf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
    .clk_i       (REF_CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (TX_HOST_VALID_I),
    .in_data_i   (tx_word),
    .in_ready_o  (tx_fifo_ready),
    .out_valid_o (TX_LINK_VALID_O),
    .out_data_o  (TX_LINK_DATA_O),
    .out_ready_i (TX_LINK_READY_I)
  );
  assign TX_HOST_READY_O = tx_fifo_ready;

  // Receive formatting: clean priority and extended code, then a trailer.
  always_comb
  begin
    rx_word       = RX_LINK_DATA_I;
    rx_idx_nxt    = rx_idx_r;
    rx_tcode_nxt  = rx_tcode_r;
    rx_st_nxt     = rx_st_r;
    rx_fifo_valid = 1'b0;
    case (rx_st_r)
      RX_DATA:
      begin
        rx_fifo_valid = RX_LINK_VALID_I;
        if (RX_LINK_SOP_I)
        begin
          // Header 0 keeps label, retry and code; priority forced to zero.
          rx_word[apf_pkg::PRI_LSB +: 4] = apf_pkg::PRIORITY_ZERO;
          rx_tcode_nxt = RX_LINK_DATA_I[apf_pkg::TCODE_LSB +: 4];
        end
        else if (rx_idx_r == 3'd3 && !is_lock(rx_tcode_r) &&
                 (rx_tcode_r == apf_pkg::TCODE_BWRITE || rx_tcode_r == apf_pkg::TCODE_BREAD ||
                  rx_tcode_r == apf_pkg::TCODE_BRESP))
        begin
          rx_word[apf_pkg::EXT_LSB +: 16] = apf_pkg::EXT_TCODE_ZERO;
        end
        // Quadlets 1 and 2 hold source ID and 48-bit offset as received.
        if (RX_LINK_VALID_I && rx_fifo_ready)
        begin
          rx_idx_nxt = RX_LINK_SOP_I ? 3'd1 : ((rx_idx_r == 3'd7) ? rx_idx_r : rx_idx_r + 3'd1);
          if (RX_LINK_EOP_I)
          begin
            rx_st_nxt = RX_TRAIL;
          end
        end
      end
      default:
      begin
        // Trailer: speed code and the returned ack code.
        rx_word       = {16'h0000, 6'h00, RX_LINK_SPEED_I, 4'h0, RX_LINK_ACK_I};
        rx_fifo_valid = 1'b1;
        if (rx_fifo_ready)
        begin
          rx_st_nxt = RX_DATA;
        end
      end
    endcase
  end

  // The link is held off while the trailer is written.
  assign RX_LINK_READY_O = rx_fifo_ready && (rx_st_r == RX_DATA);

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      rx_idx_r   <= 3'd0;
      rx_tcode_r <= 4'h0;
      rx_st_r    <= RX_DATA;
    end
    else
    begin
      rx_idx_r   <= rx_idx_nxt;
      rx_tcode_r <= rx_tcode_nxt;
      rx_st_r    <= rx_st_nxt;
    end
  end

  // Receive path buffer in arrival order.
  apf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_i       (REF_CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (rx_fifo_valid),
    .in_data_i   (rx_word),
    .in_ready_o  (rx_fifo_ready),
    .out_valid_o (RX_HOST_VALID_O),
    .out_data_o  (RX_HOST_DATA_O),
    .out_ready_i (RX_HOST_READY_I)
  );
endmodule : apf_top
`default_nettype wire

// [verif/apf_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// Port checker
// ======
module apf_top_props #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic        REF_CLK_I, SRST_I, TX_HOST_VALID_I, TX_HOST_SOP_I, TX_HOST_READY_O,
  input wire logic        TX_LINK_VALID_O, TX_LINK_READY_I, RX_LINK_VALID_I, RX_LINK_SOP_I,
  input wire logic        RX_LINK_EOP_I, RX_LINK_READY_O, RX_HOST_VALID_O, RX_HOST_READY_I,
  input wire logic [9:0]  BUS_NUMBER_I,
  input wire logic [1:0]  RX_LINK_SPEED_I,
  input wire logic [3:0]  RX_LINK_ACK_I,
  input wire logic [31:0] TX_HOST_DATA_I, TX_LINK_DATA_O, RX_LINK_DATA_I, RX_HOST_DATA_O
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  // Transmit buffer fill, counted from its two handshakes only.
  always_comb cnt_nxt = SRST_I ? 6'h00 : cnt_r + 6'(TX_HOST_VALID_I & TX_HOST_READY_O)
                        - 6'(TX_LINK_VALID_O & TX_LINK_READY_I);
  always_ff @(posedge REF_CLK_I) cnt_r <= cnt_nxt;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  tx_hold_a: assert property (TX_LINK_VALID_O && !TX_LINK_READY_I |=> TX_LINK_VALID_O && $stable(TX_LINK_DATA_O))
    else $error("transmit head changed while stalled");
  rx_hold_a: assert property (RX_HOST_VALID_O && !RX_HOST_READY_I |=> RX_HOST_VALID_O && $stable(RX_HOST_DATA_O))
    else $error("receive head changed while stalled");
  tx_answer_a: assert property (TX_HOST_VALID_I && TX_HOST_READY_O |=> TX_LINK_VALID_O)
    else $error("pushed quadlet not offered");
  rx_answer_a: assert property (RX_LINK_VALID_I && RX_LINK_READY_O |=> RX_HOST_VALID_O)
    else $error("stored quadlet not offered");
  tx_full_a: assert property (!TX_HOST_READY_O == (cnt_r == DEPTH))
    else $error("full flag disagrees with fill");
  tx_empty_a: assert property (TX_LINK_VALID_O == (cnt_r != 0))
    else $error("transmit valid disagrees with fill");
  trailer_slot_a: assert property (RX_LINK_VALID_I && RX_LINK_READY_O && RX_LINK_EOP_I |=> !RX_LINK_READY_O)
    else $error("no trailer slot after end of packet");
  reset_idle_a: assert property ($fell(SRST_I) |-> TX_HOST_READY_O && RX_LINK_READY_O && !TX_LINK_VALID_O)
    else $error("not idle after reset");
  cover property (TX_HOST_VALID_I && !TX_HOST_READY_O);
  cover property (RX_LINK_EOP_I && RX_LINK_VALID_I && RX_LINK_READY_O);
  cover property (RX_HOST_VALID_O && !RX_HOST_READY_I);
endmodule : apf_top_props
bind apf_top apf_top_props #(.DEPTH(DEPTH)) apf_top_props_inst (.*);
`default_nettype wire

// [verif/apf_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// Host processor model
// ======
module apf_host_model (
  input wire logic        clk_i, stall_i, tx_ready_i, rx_valid_i,
  input wire logic [31:0] rx_data_i,
  output logic            tx_valid_o, tx_sop_o, rx_ready_o,
  output logic [31:0]     tx_data_o
);
  logic [32:0] txq[$];
  logic [31:0] rxq[$];
  logic        took;
  initial {took, tx_valid_o, tx_sop_o, rx_ready_o, tx_data_o} = '0;
  // Record takes at the sampling edge; drained quadlets kept in arrival order.
  always @(posedge clk_i)
  begin
    took <= tx_valid_o & tx_ready_i;
    if (rx_valid_i && rx_ready_o) rxq.push_back(rx_data_i);
  end
  // Change only at the falling edge, so a request stands across the edge that takes it.
  always @(negedge clk_i)
  begin
    if (took || !tx_valid_o)
    begin
      tx_valid_o = txq.size() != 0;
      if (tx_valid_o) {tx_sop_o, tx_data_o} = txq.pop_front();
      else tx_data_o = ~tx_data_o;
    end
    rx_ready_o = stall_i ? !rx_ready_o : 1'b1;
  end
endmodule : apf_host_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
// ======
// Testbench
// ======
module testbench;
  logic        clk = 1'b0, srst = 1'b1, tx_lrdy = 1'b0, tx_hold = 1'b0, stall = 1'b0;
  logic        rx_v = 1'b0, rx_sop = 1'b0, rx_eop = 1'b0;
  logic [9:0]  bus_num = 10'h155;
  logic [1:0]  spd = 2'h0;
  logic [3:0]  ack = 4'h0;
  logic [31:0] rx_d = 32'h0;
  wire         h_tv, h_ts, h_tr, l_tv, r_lr, r_hv, r_hr;
  wire  [31:0] h_td, l_td, r_hd;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  logic [31:0] txo[$];
  logic [31:0] want_q[$];
  always #12.5 clk = ~clk;
  apf_top #(.WIDTH(32), .DEPTH(16)) apf_top_inst (.REF_CLK_I(clk), .SRST_I(srst), .BUS_NUMBER_I(bus_num),
    .TX_HOST_VALID_I(h_tv), .TX_HOST_DATA_I(h_td), .TX_HOST_SOP_I(h_ts), .TX_HOST_READY_O(h_tr),
    .TX_LINK_VALID_O(l_tv), .TX_LINK_DATA_O(l_td), .TX_LINK_READY_I(tx_lrdy), .RX_LINK_VALID_I(rx_v),
    .RX_LINK_DATA_I(rx_d), .RX_LINK_SOP_I(rx_sop), .RX_LINK_EOP_I(rx_eop), .RX_LINK_SPEED_I(spd),
    .RX_LINK_ACK_I(ack), .RX_LINK_READY_O(r_lr), .RX_HOST_VALID_O(r_hv), .RX_HOST_DATA_O(r_hd),
    .RX_HOST_READY_I(r_hr));
  apf_host_model host (.clk_i(clk), .stall_i(stall), .tx_ready_i(h_tr), .rx_valid_i(r_hv), .rx_data_i(r_hd),
    .tx_valid_o(h_tv), .tx_sop_o(h_ts), .rx_ready_o(r_hr), .tx_data_o(h_td));
  // Link side stalls every third cycle; a hang is cut short by the cycle ceiling.
  always @(negedge clk) tx_lrdy = !tx_hold && (cyc % 3 != 0);
  always @(posedge clk)
  begin
    cyc++;
    if (l_tv && tx_lrdy) txo.push_back(l_td);
    if (cyc == 4000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task check_stream(input logic [31:0] got[$]);
    `CHK(got.size(), want_q.size())
    foreach (want_q[i]) `CHK(got[i], want_q[i])
    want_q.delete();
  endtask : check_stream
  // Bus select set and clear on quadlet write packets.
  task t_tx_bus;
    logic [31:0] q0;
    bus_num = 10'h2C3;
    for (int s = 0; s < 2; s++)
    begin
      q0 = {8'h00, s[0], 7'h00, 6'(s + 3), 2'b00, apf_pkg::TCODE_QWRITE, apf_pkg::PRIORITY_ZERO};
      host.txq.push_back({1'b1, q0});
      host.txq.push_back({1'b0, 10'h2AA, 6'h05, 16'hFFFF});
      host.txq.push_back({1'b0, 32'h1234_5670});
      host.txq.push_back({1'b0, 32'hCAFE_0001});
      want_q.push_back(q0);
      want_q.push_back({s ? apf_pkg::LOCAL_BUS_NUM : bus_num, 6'h05, 16'hFFFF});
      want_q.push_back(32'h1234_5670);
      want_q.push_back(32'hCAFE_0001);
    end
    // Block write with programmed bus number, six data bytes and a padded tail.
    q0 = {8'h00, 1'b0, 7'h00, 6'h07, 2'b00, apf_pkg::TCODE_BWRITE, apf_pkg::PRIORITY_ZERO};
    host.txq.push_back({1'b1, q0});
    host.txq.push_back({1'b0, 10'h2AA, 6'h05, 16'hFFFF});
    host.txq.push_back({1'b0, 32'h1234_5678});
    host.txq.push_back({1'b0, 16'h0006, apf_pkg::EXT_TCODE_ZERO});
    host.txq.push_back({1'b0, 32'hA1A2_A3A4});
    host.txq.push_back({1'b0, 16'hB1B2, 16'h0000});
    want_q.push_back(q0);
    want_q.push_back({bus_num, 6'h05, 16'hFFFF});
    want_q.push_back(32'h1234_5678);
    want_q.push_back({16'h0006, apf_pkg::EXT_TCODE_ZERO});
    want_q.push_back(32'hA1A2_A3A4);
    want_q.push_back({16'hB1B2, 16'h0000});
    repeat (40) @(posedge clk);
    check_stream(txo);
    txo.delete();
    $display("tx bus select test done");
  endtask : t_tx_bus
  // Fill the transmit buffer past its depth, then drain in order.
  task t_tx_fill;
    tx_hold = 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      host.txq.push_back({1'b0, 32'(i)});
      want_q.push_back(32'(i));
    end
    repeat (30) @(negedge clk);
    `CHK(h_tr, 1'b0)
    tx_hold = 1'b0;
    repeat (60) @(posedge clk);
    check_stream(txo);
    txo.delete();
    $display("tx fill test done");
  endtask : t_tx_fill
  task rx_word(input logic [31:0] d, input logic s, input logic e);
    @(negedge clk);
    rx_d = d;
    rx_sop = s;
    rx_eop = e;
    rx_v = 1'b1;
    while (!r_lr) @(negedge clk);
    @(posedge clk);
  endtask : rx_word
  // Received block and lock packets with a slow draining host.
  task t_rx;
    logic [3:0] codes[5];
    codes = '{apf_pkg::TCODE_BWRITE, apf_pkg::TCODE_BREAD, apf_pkg::TCODE_BRESP,
              apf_pkg::TCODE_LOCK_REQ, apf_pkg::TCODE_LOCK_RSP};
    stall = 1'b1;
    foreach (codes[i])
    begin
      @(negedge clk);
      spd = 2'(i);
      ack = 4'(i + 1);
      rx_word({16'hFFC1, 6'(i), 2'b01, codes[i], 4'hA}, 1'b1, 1'b0);
      want_q.push_back({16'hFFC1, 6'(i), 2'b01, codes[i], 4'h0});
      rx_word(32'hFFC2_0000, 1'b0, 1'b0);
      rx_word(32'h8765_4321, 1'b0, 1'b0);
      rx_word(32'h0010_BEEF, 1'b0, 1'b0);
      rx_word(32'h0000_00A5, 1'b0, 1'b1);
      want_q.push_back(32'hFFC2_0000);
      want_q.push_back(32'h8765_4321);
      want_q.push_back({16'h0010, codes[i][3] ? 16'hBEEF : apf_pkg::EXT_TCODE_ZERO});
      want_q.push_back(32'h0000_00A5);
      want_q.push_back({22'h0, spd, 4'h0, ack});
      @(negedge clk);
      rx_v = 1'b0;
      rx_d = ~rx_d;
      // Speed and ack must stand until the trailer is stored, which a full buffer may delay.
      while (!r_lr) @(negedge clk);
      @(posedge clk);
    end
    stall = 1'b0;
    repeat (40) @(posedge clk);
    check_stream(host.rxq);
    $display("rx store test done");
  endtask : t_rx
  initial
  begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_tx_bus();
    t_tx_fill();
    t_rx();
    final_report();
  end
endmodule : testbench
`default_nettype wire
